// file: src/p3pd_pkg.sv
/*
 * constants for the port 3 latch / alternate function mux and the
 * port 2 low drive-mode register.
 * assumes a single core clock and a byte-wide special-function bus.
 */
package p3pd_pkg;
    // register addresses on the special-function bus
    localparam logic [7:0] ADDR_P3_LATCH  = 8'hB0;
    localparam logic [7:0] ADDR_P2_LO_CFG = 8'hB1;
    // reset values
    localparam logic [7:0] RST_P3_LATCH   = 8'hFF;
    localparam logic [7:0] RST_P2_LO_CFG  = 8'h00;
    // port 3 pin positions
    localparam int PIN_RD   = 7;
    localparam int PIN_WR   = 6;
    localparam int PIN_CNT1 = 5;
    localparam int PIN_CNT0 = 4;
    localparam int PIN_IRQ1 = 3;
    localparam int PIN_IRQ0 = 2;
    localparam int PIN_TXD  = 1;
    localparam int PIN_RXD  = 0;
    // width of one pin mode field
    localparam int MODE_W   = 2;
    // two-bit pin drive modes
    typedef enum logic [1:0] {
        MODE_QUASI = 2'b00,
        MODE_PUSH  = 2'b01,
        MODE_OPEN  = 2'b10,
        MODE_INPUT = 2'b11
    } p3pd_mode_type;
    // serial port mode with a shift-register data line
    localparam logic [1:0] SER_MODE_SHIFT = 2'b00;
endpackage : p3pd_pkg

// file: src/p3pd_top.sv
/*
 * port 3 latch with alternate pin functions, and port 2 pins 0-3
 * drive-mode configuration.
 * assumes pins, core strobes and config bits are synchronous to clk;
 * pad cells resolve out / oe_n / pull-up into the wire level.
 */
// Contract
// - the port 3 latch is a general-purpose port that resets to all ones.
// - except on pins 7 and 6 with external memory selected, an alternate function only acts on a pin whose latch bit is one;
//   a zero drives the pin low unless its drive mode is 11 (input), which leaves it undriven.
// - pin 7 carries the active-low external data read strobe.
// - pin 6 carries the active-low external data write strobe.
// - with external memory selected the strobes work whatever the latch bits hold.
// - with external memory selected the strobe pins ignore the port 3 high drive config.
// - a falling edge on pin 5 counts timer 1, on pin 4 timer 0, when counting events.
// - pin 0 is the serial 0 receive input in serial modes 1, 2 and 3.
// - in serial mode 0 pin 0 is a bidirectional data line.
// - an 8-bit port 2 low drive register, two bits per pin, resets to zero.
// - bits 7-6 set port 2 pin 3 and bits 5-4 pin 2, upper bit first.
// - mode 00 quasi pull-up, 01 push-pull, 10 open drain, 11 input.
// - bits 3-2 set port 2 pin 1 and bits 1-0 pin 0 in the same code.
// - external access or port 2 memory enable overrides the port 2 drive modes.
`timescale 1ns/100ps
module p3pd_top (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // special-function bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    // configuration from outside this block
    input  wire logic       ext_mem_sel_p0,
    input  wire logic       ext_mem_sel_p2,
    input  wire logic       external_access_input,
    input  wire logic [7:0] port3_high_pin_drive_config,
    input  wire logic [7:0] port3_low_pin_drive_config,
    // core side alternate functions
    input  wire logic       xdata_rd_n,
    input  wire logic       xdata_wr_n,
    input  wire logic       cnt0_ext_en,
    input  wire logic       cnt1_ext_en,
    input  wire logic [1:0] irq_edge_mode,
    input  wire logic [1:0] irq_en,
    input  wire logic [1:0] ser_mode,
    input  wire logic       serial_zero_transmit,
    input  wire logic       ser_shift_clk,
    input  wire logic       ser_shift_dout,
    input  wire logic       ser_shift_drive,
    output logic            counter_zero_event_input,
    output logic            counter_one_event_input,
    output logic [1:0]      ext_irq_req,
    output logic            serial_zero_receive,
    // port 3 pins
    input  wire logic [7:0] p3_in,
    output logic      [7:0] p3_out,
    output logic      [7:0] p3_oe_n,
    output logic      [7:0] p3_pullup,
    // port 2 pins 0-3
    input  wire logic [3:0] p2_latch_data,
    input  wire logic [3:0] p2_addr_data,
    output logic      [3:0] p2_out,
    output logic      [3:0] p2_oe_n,
    output logic      [3:0] p2_pullup
);

    ////////////////////////////////////////////////////////////////////
    // pad driver: {oe_n, pullup} from mode and data
    function automatic logic [1:0] drv(input logic [1:0] m, input logic d);
        case (m)
            p3pd_pkg::MODE_QUASI: drv = {d, d};
            p3pd_pkg::MODE_PUSH:  drv = 2'b00;
            p3pd_pkg::MODE_OPEN:  drv = {d, 1'b0};
            p3pd_pkg::MODE_INPUT: drv = 2'b10;
            default:              drv = 2'b10;
        endcase
    endfunction : drv

    logic [7:0] latch_r;
    logic [7:0] p2cfg_r;
    logic [7:0] smp_r;
    logic [7:0] rdata_r;
    logic [7:0] p3_out_r;
    logic [7:0] p3_oe_n_r;
    logic [7:0] p3_pu_r;
    logic [3:0] p2_out_r;
    logic [3:0] p2_oe_n_r;
    logic [3:0] p2_pu_r;
    logic       cnt0_r;
    logic       cnt1_r;
    logic [1:0] irq_r;
    logic       rx_r;
    logic       ext_mem;
    logic       p2_ovr;
    logic       shift_mode;
    logic [7:0] alt;
    logic [7:0] dat;
    logic [15:0] p3cfg;
    logic [7:0] p3_oe_n_nxt;
    logic [7:0] p3_pu_nxt;
    logic [3:0] p2_dat;
    logic [3:0] p2_oe_n_nxt;
    logic [3:0] p2_pu_nxt;

    assign ext_mem    = ext_mem_sel_p0 | ext_mem_sel_p2;
    assign p2_ovr     = ~external_access_input | ext_mem_sel_p2;
    assign shift_mode = (ser_mode == p3pd_pkg::SER_MODE_SHIFT);
    assign p3cfg      = {port3_high_pin_drive_config, port3_low_pin_drive_config};

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_r <= p3pd_pkg::RST_P3_LATCH;
        end else if (sfr_wr && sfr_addr == p3pd_pkg::ADDR_P3_LATCH) begin
            latch_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p2cfg_r <= p3pd_pkg::RST_P2_LO_CFG;
        end else if (sfr_wr && sfr_addr == p3pd_pkg::ADDR_P2_LO_CFG) begin
            p2cfg_r <= sfr_wdata;
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                p3pd_pkg::ADDR_P3_LATCH:  rdata_r <= latch_r;
                p3pd_pkg::ADDR_P2_LO_CFG: rdata_r <= p2cfg_r;
                default:                  rdata_r <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port 3 output mux
    always_comb begin
        alt                     = 8'hFF;
        alt[p3pd_pkg::PIN_RD]   = xdata_rd_n;
        alt[p3pd_pkg::PIN_WR]   = xdata_wr_n;
        alt[p3pd_pkg::PIN_TXD]  = shift_mode ? ser_shift_clk : serial_zero_transmit;
        alt[p3pd_pkg::PIN_RXD]  = (shift_mode && ser_shift_drive) ? ser_shift_dout : 1'b1;
        dat                     = latch_r & alt;
        if (ext_mem) begin
            dat[p3pd_pkg::PIN_RD] = xdata_rd_n;
            dat[p3pd_pkg::PIN_WR] = xdata_wr_n;
        end
        for (int i = 0; i < 8; i++) begin
            {p3_oe_n_nxt[i], p3_pu_nxt[i]} = drv(p3cfg[i*p3pd_pkg::MODE_W +: p3pd_pkg::MODE_W], dat[i]);
        end
        if (ext_mem) begin
            p3_oe_n_nxt[p3pd_pkg::PIN_RD] = 1'b0;
            p3_oe_n_nxt[p3pd_pkg::PIN_WR] = 1'b0;
            p3_pu_nxt[p3pd_pkg::PIN_RD]   = 1'b0;
            p3_pu_nxt[p3pd_pkg::PIN_WR]   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_out_r  <= 8'hFF;
            p3_oe_n_r <= 8'hFF;
            p3_pu_r   <= 8'hFF;
        end else begin
            p3_out_r  <= dat;
            p3_oe_n_r <= p3_oe_n_nxt;
            p3_pu_r   <= p3_pu_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port 2 pins 0-3: field i*2+1 upper, i*2 lower
    always_comb begin
        p2_dat = p2_ovr ? p2_addr_data : p2_latch_data;
        for (int i = 0; i < 4; i++) begin
            {p2_oe_n_nxt[i], p2_pu_nxt[i]} =
                drv(p2cfg_r[i*p3pd_pkg::MODE_W +: p3pd_pkg::MODE_W], p2_dat[i]);
        end
        if (p2_ovr) begin
            p2_oe_n_nxt = 4'h0;
            p2_pu_nxt   = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p2_out_r  <= 4'hF;
            p2_oe_n_r <= 4'hF;
            p2_pu_r   <= 4'hF;
        end else begin
            p2_out_r  <= p2_dat;
            p2_oe_n_r <= p2_oe_n_nxt;
            p2_pu_r   <= p2_pu_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alternate inputs: edge detect against last sample, except irq level mode, which uses the pin alone
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            smp_r <= 8'hFF;
        end else begin
            smp_r <= p3_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt0_r <= 1'b0;
            cnt1_r <= 1'b0;
        end else begin
            cnt0_r <= cnt0_ext_en & latch_r[p3pd_pkg::PIN_CNT0]
                      & smp_r[p3pd_pkg::PIN_CNT0] & ~p3_in[p3pd_pkg::PIN_CNT0];
            cnt1_r <= cnt1_ext_en & latch_r[p3pd_pkg::PIN_CNT1]
                      & smp_r[p3pd_pkg::PIN_CNT1] & ~p3_in[p3pd_pkg::PIN_CNT1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_r <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                irq_r[i] <= irq_en[i] & latch_r[p3pd_pkg::PIN_IRQ0+i] & ~p3_in[p3pd_pkg::PIN_IRQ0+i]
                            & (~irq_edge_mode[i] | smp_r[p3pd_pkg::PIN_IRQ0+i]);
            end
        end
    end

    // mode 0 receives on the same pin while not driving it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_r <= 1'b1;
        end else begin
            rx_r <= ~latch_r[p3pd_pkg::PIN_RXD] | p3_in[p3pd_pkg::PIN_RXD];
        end
    end

    assign sfr_rdata                = rdata_r;
    assign p3_out                   = p3_out_r;
    assign p3_oe_n                  = p3_oe_n_r;
    assign p3_pullup                = p3_pu_r;
    assign p2_out                   = p2_out_r;
    assign p2_oe_n                  = p2_oe_n_r;
    assign p2_pullup                = p2_pu_r;
    assign counter_zero_event_input = cnt0_r;
    assign counter_one_event_input  = cnt1_r;
    assign ext_irq_req              = irq_r;
    assign serial_zero_receive      = rx_r;

    ////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_fall5;
        (p3_in[5] && latch_r[5] && cnt1_ext_en) ##1 (!p3_in[5] && latch_r[5] && cnt1_ext_en);
    endsequence
    sequence s_wr_then_rd;
        sfr_wr && sfr_addr == p3pd_pkg::ADDR_P2_LO_CFG
        ##1 sfr_rd && sfr_addr == p3pd_pkg::ADDR_P2_LO_CFG && !sfr_wr;
    endsequence

    property p_rst_latch;
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> latch_r == p3pd_pkg::RST_P3_LATCH && p2cfg_r == p3pd_pkg::RST_P2_LO_CFG;
    endproperty
    a_rst_latch: assert property (p_rst_latch) else $error("bad reset value");
    property p_zero_low;
        @(posedge clk) disable iff (!rst_n)
        !latch_r[5] && port3_high_pin_drive_config[3:2] != 2'b11 |=> !p3_out[5] && !p3_oe_n[5];
    endproperty
    a_zero_low: assert property (p_zero_low) else $error("zero latch not driven low");
    property p_rd_strobe;
        @(posedge clk) disable iff (!rst_n) ext_mem && !xdata_rd_n |=> !p3_out[7] && !p3_oe_n[7];
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");
    property p_wr_strobe;
        @(posedge clk) disable iff (!rst_n) ext_mem && !xdata_wr_n |=> !p3_out[6] && !p3_oe_n[6];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");
    property p_strobe_ovr;
        @(posedge clk) disable iff (!rst_n) ext_mem && !latch_r[7] && xdata_rd_n |=> p3_out[7];
    endproperty
    a_strobe_ovr: assert property (p_strobe_ovr) else $error("latch blocked strobe");
    property p_strobe_drive;
        @(posedge clk) disable iff (!rst_n) ext_mem |=> p3_oe_n[7:6] == 2'b00 && p3_pullup[7:6] == 2'b00;
    endproperty
    a_strobe_drive: assert property (p_strobe_drive) else $error("strobe not push-pull");
    property p_count1;
        @(posedge clk) disable iff (!rst_n) s_fall5 |=> counter_one_event_input ##1 !counter_one_event_input;
    endproperty
    a_count1: assert property (p_count1) else $error("falling edge not counted");
    property p_rx;
        @(posedge clk) disable iff (!rst_n) latch_r[0] |=> serial_zero_receive == $past(p3_in[0]);
    endproperty
    a_rx: assert property (p_rx) else $error("receive input wrong");
    property p_p2_push;
        @(posedge clk) disable iff (!rst_n)
        p2cfg_r[7:6] == 2'b01 && external_access_input && !ext_mem_sel_p2 |=> !p2_oe_n[3] && !p2_pullup[3];
    endproperty
    a_p2_push: assert property (p_p2_push) else $error("pin 3 mode decode wrong");
    property p_p2_ovr;
        @(posedge clk) disable iff (!rst_n) ext_mem_sel_p2 |=> p2_oe_n == 4'h0 && p2_out == $past(p2_addr_data);
    endproperty
    a_p2_ovr: assert property (p_p2_ovr) else $error("port 2 override missing");
    property p_cfg_rd;
        @(posedge clk) disable iff (!rst_n) s_wr_then_rd |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");

endmodule : p3pd_top

// file: test/p3pd_pins.sv
/* pin model for the port 3 wires and the external memory strobes.
   assumes registered pad controls from the block and bench-owned board drivers. */
`timescale 1ns/100ps
module p3pd_pins (
    // clock
    input  wire logic       clk,
    // pad controls
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p3_oe_n,
    input  wire logic [7:0] p3_pullup,
    // board drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // wires and strobe fall counts
    output logic      [7:0] p3_in,
    output logic      [7:0] rd_cnt,
    output logic      [7:0] wr_cnt
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] rd_r   = 8'h00;
    logic [7:0] wr_r   = 8'h00;
    assign rd_cnt = rd_r;
    assign wr_cnt = wr_r;
    // floating pin without pull-up toggles, never holds
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!p3_oe_n[i]) p3_in[i] = p3_out[i];
            else if (ext_en[i]) p3_in[i] = ext_val[i];
            else p3_in[i] = p3_pullup[i] | ~last_r[i];
        end
    end
    always @(posedge clk) begin
        last_r <= p3_in;
        if (last_r[7] && !p3_in[7] && !p3_oe_n[7]) rd_r <= rd_r + 8'h01;
        if (last_r[6] && !p3_in[6] && !p3_oe_n[6]) wr_r <= wr_r + 8'h01;
    end
endmodule : p3pd_pins

// file: test/testbench.sv
/* self-checking bench for p3pd_top: registers, strobes, events, serial, port 2.
   assumes p3pd_pins resolves the port 3 wires. */
`timescale 1ns/100ps
module testbench;
    logic       clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic       ext_mem_sel_p0 = 1'b0, ext_mem_sel_p2 = 1'b0, external_access_input = 1'b1;
    logic [7:0] port3_high_pin_drive_config = 8'h00, port3_low_pin_drive_config = 8'h00;
    logic       xdata_rd_n = 1'b1, xdata_wr_n = 1'b1, cnt0_ext_en = 1'b1, cnt1_ext_en = 1'b1;
    logic [1:0] irq_edge_mode = 2'b00, irq_en = 2'b11, ser_mode = 2'b01;
    logic       serial_zero_transmit = 1'b1, ser_shift_clk = 1'b0, ser_shift_dout = 1'b1;
    logic       ser_shift_drive = 1'b0;
    logic [3:0] p2_latch_data = 4'h0, p2_addr_data = 4'h0, p2_out, p2_oe_n, p2_pullup;
    logic [7:0] sfr_rdata, p3_in, p3_out, p3_oe_n, p3_pullup, rd_cnt, wr_cnt, r0, w0;
    logic       counter_zero_event_input, counter_one_event_input, serial_zero_receive;
    logic [1:0] ext_irq_req;
    int         error_cnt = 0, compares = 0, hits [4];

    p3pd_top u_p3pd_top (.clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .ext_mem_sel_p0,
        .ext_mem_sel_p2, .external_access_input, .port3_high_pin_drive_config, .port3_low_pin_drive_config,
        .xdata_rd_n, .xdata_wr_n, .cnt0_ext_en, .cnt1_ext_en, .irq_edge_mode, .irq_en, .ser_mode,
        .serial_zero_transmit, .ser_shift_clk, .ser_shift_dout, .ser_shift_drive, .counter_zero_event_input,
        .counter_one_event_input, .ext_irq_req, .serial_zero_receive, .p3_in, .p3_out, .p3_oe_n, .p3_pullup,
        .p2_latch_data, .p2_addr_data, .p2_out, .p2_oe_n, .p2_pullup);
    p3pd_pins u_p3pd_pins (.clk, .p3_out, .p3_oe_n, .p3_pullup, .ext_en, .ext_val, .p3_in, .rd_cnt, .wr_cnt);

    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
        #1;
        chk("sfr_rdata", exp, sfr_rdata);
    endtask : rd
    // high 3 cycles, low 6, high again; counts event outputs each cycle
    task automatic pulse_pin(input int p);
        logic [3:0] ev;
        for (int b = 0; b < 4; b++) hits[b] = 0;
        for (int i = 0; i < 18; i++) begin
            @(posedge clk);
            ext_en[p]  <= 1'b1;
            ext_val[p] <= (i < 3 || i > 8);
            #1;
            ev = {ext_irq_req, counter_one_event_input, counter_zero_event_input};
            for (int b = 0; b < 4; b++) hits[b] += (ev[b] === 1'b1);
        end
        @(posedge clk);
        ext_en[p] <= 1'b0;
    endtask : pulse_pin
    task automatic p2_case(input logic [7:0] cfg, input logic [3:0] d, input logic [3:0] eoe,
                           input logic [3:0] msk, input logic [3:0] epu);
        wr(8'hB1, cfg);
        p2_latch_data <= d;
        step(2);
        chk("p2_oe_n", eoe, p2_oe_n);
        chk("p2_pullup", epu, p2_pullup & msk);
    endtask : p2_case
    task automatic summarize;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        chk("p3_out", 8'hFF, p3_out);
        chk("p3_pullup", 8'hFF, p3_pullup);
        rd(8'hB0, 8'hFF);
        rd(8'hB1, 8'h00);
        wr(8'hB1, 8'h5A);
        wr(8'hB0, 8'h3C);
        wr(8'hB2, 8'hFF);
        rd(8'hB1, 8'h5A);
        rd(8'hB0, 8'h3C);
        rd(8'hB2, 8'h00);
        chk("p3_out", 8'h3C, p3_out);
        chk("p3_pullup", 8'h3C, p3_pullup);
        // strobes forced through zero latch bits and input-mode config
        @(posedge clk);
        ext_mem_sel_p0 <= 1'b1;
        port3_high_pin_drive_config <= 8'hF0;
        xdata_wr_n <= 1'b0;
        step(2);
        r0 = rd_cnt;
        w0 = wr_cnt;
        chk("strobe", 8'h02, p3_out[7:6]);
        chk("strobe_oe", 8'h00, p3_oe_n[7:6]);
        @(posedge clk);
        xdata_rd_n <= 1'b0;
        xdata_wr_n <= 1'b1;
        step(2);
        chk("rd_strobe", 8'h01, p3_out[7:6]);
        chk("rd_falls", r0 + 8'h01, rd_cnt);
        @(posedge clk);
        xdata_rd_n <= 1'b1;
        xdata_wr_n <= 1'b0;
        step(2);
        chk("wr_falls", w0 + 8'h01, wr_cnt);
        @(posedge clk);
        ext_mem_sel_p0 <= 1'b0;
        xdata_wr_n <= 1'b1;
        step(2);
        chk("blocked", 8'h00, p3_out[7:6]);
        chk("cfg_oe", 8'h03, p3_oe_n[7:6]);
        chk("cfg_pu", 8'h00, p3_pullup[7:6]);
        @(posedge clk);
        port3_high_pin_drive_config <= 8'h00;
        wr(8'hB0, 8'hFF);
        pulse_pin(5);
        chk("cnt1", 8'h01, 8'(hits[1]));
        chk("cnt0", 8'h00, 8'(hits[0]));
        pulse_pin(4);
        chk("cnt0", 8'h01, 8'(hits[0]));
        pulse_pin(2);
        chk("irq0_level", 8'h06, 8'(hits[2]));
        irq_edge_mode <= 2'b10;
        cnt1_ext_en <= 1'b0;
        pulse_pin(3);
        chk("irq1_edge", 8'h01, 8'(hits[3]));
        pulse_pin(5);
        chk("cnt1_off", 8'h00, 8'(hits[1]));
        cnt1_ext_en <= 1'b1;
        wr(8'hB0, 8'hDF);
        pulse_pin(5);
        chk("cnt1_gated", 8'h00, 8'(hits[1]));
        wr(8'hB0, 8'hFF);
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b0;
        serial_zero_transmit <= 1'b0;
        step(2);
        chk("rx", 8'h00, serial_zero_receive);
        chk("tx", 8'h00, p3_out[1]);
        @(posedge clk);
        ext_en[0] <= 1'b0;
        ser_mode <= 2'b00;
        ser_shift_clk <= 1'b1;
        ser_shift_drive <= 1'b1;
        ser_shift_dout <= 1'b0;
        step(2);
        chk("shift_clk", 8'h01, p3_out[1]);
        chk("shift_dat", 8'h00, {p3_out[0], p3_oe_n[0], serial_zero_receive});
        @(posedge clk);
        ser_shift_drive <= 1'b0;
        step(2);
        chk("shift_rel", 8'h01, serial_zero_receive);
        // back-to-back write then read of the port 2 config
        @(posedge clk);
        sfr_addr  <= 8'hB1;
        sfr_wdata <= 8'hC3;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        sfr_rd    <= 1'b1;
        @(posedge clk);
        sfr_rd    <= 1'b0;
        #1;
        chk("wr_rd", 8'hC3, sfr_rdata);
        p2_case(8'hE4, 4'h0, 4'h8, 4'hD, 4'h0);
        p2_case(8'hE4, 4'hF, 4'hD, 4'hD, 4'h1);
        p2_case(8'h1B, 4'hF, 4'hB, 4'hB, 4'h8);
        @(posedge clk);
        p2_addr_data <= 4'hA;
        external_access_input <= 1'b0;
        step(2);
        chk("p2_ovr", 8'hA0, {p2_out, p2_oe_n | p2_pullup});
        @(posedge clk);
        external_access_input <= 1'b1;
        ext_mem_sel_p2 <= 1'b1;
        step(2);
        chk("p2_sel", 8'hA0, {p2_out, p2_oe_n | p2_pullup});
        chk("strobe_oe", 8'h00, p3_oe_n[7:6]);
        summarize();
    end
endmodule : testbench
